// ==== src/sso_pkg.sv ====
// Shared constants, types and helpers for the servo status output logic
package sso_pkg;

   // ------------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------------
   localparam int SPEED_W  = 16;             // Signed speed sample, r/min
   localparam int ASPEED_W = SPEED_W + 1;    // Magnitude keeps -32768 exact
   localparam int CODE_W   = 3;              // Alarm group code width
   localparam int DIGIT_W  = 4;              // One parameter digit
   localparam int START_W  = 26;             // Start-up counter width

   // ------------------------------------------------------------------
   // Speed levels, r/min
   // ------------------------------------------------------------------
   localparam logic [SPEED_W-1:0] ZERO_SPEED_DEFAULT = 16'h0032;  // 50 r/min
   localparam logic [SPEED_W-1:0] ZERO_SPEED_HYST    = 16'h0014;  // 20 r/min

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_KHZ         = 40000;   // 40 MHz clock
   localparam int STARTUP_MAX_MS  = 1500;    // Warning outputs settle, ms
   // Longest time in clock cycles, exact product with no rounding
   localparam int STARTUP_CYC     = STARTUP_MAX_MS * CLK_KHZ;

   // ------------------------------------------------------------------
   // Parameter digit encodings
   // ------------------------------------------------------------------
   localparam logic [DIGIT_W-1:0] DIGIT_ON = 4'h1;  // Lowest digit set to 1

   // Signal routed to the single assignable output pin
   typedef enum logic [1:0] {
      SSO_PIN_SPEED_REACHED = 2'h0,
      SSO_PIN_BRAKE         = 2'h1,
      SSO_PIN_WARNING       = 2'h2,
      SSO_PIN_BATTERY_WARN  = 2'h3
   } sso_pin_sel_t;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [SPEED_W-1:0] zero_speed_threshold_param;  // Unsigned r/min
      logic [DIGIT_W-1:0] function_select_param;       // Low digit 1: brake
      logic [DIGIT_W-1:0] alarm_code_select_param;     // Low digit 1: codes
      sso_pin_sel_t       output_pin_assign_param;     // Assignable pin
   } sso_cfg_t;

   typedef struct packed {
      logic ready;
      logic in_position_out;
      logic speed_reached_out;
   } sso_sts_t;

   typedef struct packed {
      logic              active;
      logic [CODE_W-1:0] group;
   } sso_alarm_t;

   typedef struct packed {
      logic warning;
      logic battery_cable;
      logic battery_low;
   } sso_warn_t;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [ASPEED_W-1:0] sso_abs(input logic signed [SPEED_W-1:0] v);
      logic [ASPEED_W-1:0] w;
      w = {v[SPEED_W-1], v};
      sso_abs = v[SPEED_W-1] ? ASPEED_W'(~w + 1'b1) : w;
   endfunction : sso_abs

   function automatic logic sso_digit_on(input logic [DIGIT_W-1:0] d);
      sso_digit_on = (d == DIGIT_ON);
   endfunction : sso_digit_on

endpackage : sso_pkg

// ==== src/sso_zero_speed.sv ====
// Zero-speed comparator with hysteresis, one step per speed sample
`timescale 1ns/1ps

module sso_zero_speed (
   input  wire logic                                i_clk,        // 40 MHz clock
   input  wire logic                                i_rst_n,      // Sync reset, low
   input  wire logic signed [sso_pkg::SPEED_W-1:0]  i_speed,      // Measured speed
   input  wire logic                                i_speed_vld,  // Sample strobe
   input  wire logic        [sso_pkg::SPEED_W-1:0]  i_threshold,  // On level
   output logic                                     o_zero        // Zero-speed flag
);

   typedef enum logic {SSO_ZS_MOVING, SSO_ZS_STOPPED} sso_zs_state_t;

   sso_zs_state_t                  state_ff;
   sso_zs_state_t                  nxt_state;
   logic [sso_pkg::ASPEED_W-1:0]   mag;
   logic [sso_pkg::ASPEED_W-1:0]   on_lvl;
   logic [sso_pkg::ASPEED_W-1:0]   off_lvl;

   // ------------------------------------------------------------------
   // Levels
   // ------------------------------------------------------------------
   // R4 both directions
   assign mag     = sso_pkg::sso_abs(i_speed);
   assign on_lvl  = {1'b0, i_threshold};
   // R5 off above on
   assign off_lvl = on_lvl + {1'b0, sso_pkg::ZERO_SPEED_HYST};

   // Next state, evaluated only on a fresh sample
   // R16 two-state compare
   always_comb begin
      nxt_state = state_ff;
      if (i_speed_vld) begin
         unique case (state_ff)
            // R1 on at threshold
            SSO_ZS_MOVING:  if (mag <= on_lvl) nxt_state = SSO_ZS_STOPPED;
            // R3 off at off level
            SSO_ZS_STOPPED: if (mag >= off_lvl) nxt_state = SSO_ZS_MOVING;
         endcase
      end
   end

   // State register; reset assumes motion until the first sample
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) state_ff <= SSO_ZS_MOVING;
      else          state_ff <= nxt_state;
   end

   assign o_zero = (state_ff == SSO_ZS_STOPPED);

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   zs_turn_on_a: assert property (i_speed_vld && mag <= on_lvl |=> o_zero)  // R1
      else $error("zero-speed flag missed the on level");
   zs_turn_off_a: assert property (i_speed_vld && mag >= off_lvl |=> !o_zero)  // R3
      else $error("zero-speed flag missed the off level");
   zs_hyst_hold_a: assert property (o_zero && i_speed_vld && mag < off_lvl |=> o_zero)  // R5
      else $error("zero-speed flag dropped inside hysteresis");
   zs_idle_hold_a: assert property (!i_speed_vld |=> $stable(o_zero))  // R16
      else $error("zero-speed flag moved without a sample");

endmodule : sso_zero_speed

// ==== src/sso_status_out.sv ====
// Discrete status output logic of the servo driver
`timescale 1ns/1ps

// Summary of operation
// R1: Zero-speed flag sets when absolute speed is at or below threshold.
// R2: Threshold comes from a configuration input, default 50 r/min.
// R3: Once set, flag clears only when speed climbs to the off level.
// R4: Detection uses absolute speed, so both directions behave alike.
// R5: Off level is threshold plus 20 r/min hysteresis.
// R6: Brake interlock only when enabled; zero-speed output then forced off.
// R7: Brake interlock drops when servo is off or an alarm is active.
// R8: Warning output follows warnings only while assigned to the pin.
// R9: Warning output is inactive within 1.5 s of power-on.
// R10: Battery warning output follows cable-disconnect or low-battery warning only while assigned to the pin.
// R11: Battery warning output is inactive within 1.5 s of power-on.
// R12: Assigning a signal to the optional pin replaces the previous one.
// R13: Alarm codes only when the code-select low digit equals 1.
// R14: During alarm three pins carry the group code, else normal status.
// R15: Code holds until alarm clears, then pins return next update.
// R16: Comparator is a two-state machine updated per speed sample.
module sso_status_out #(
   parameter int P_STARTUP_CYC = sso_pkg::STARTUP_CYC  // Settle time, cycles
) (
   input  wire logic                                i_clk,                  // 40 MHz clock
   input  wire logic                                i_rst_n,                // Sync reset, low
   input  wire logic signed [sso_pkg::SPEED_W-1:0]  i_speed,                // Speed, r/min
   input  wire logic                                i_speed_vld,            // Speed sample strobe
   input  wire logic                                i_servo_on,             // Servo switched on
   input  wire sso_pkg::sso_cfg_t                   i_cfg,                  // Parameter settings
   input  wire sso_pkg::sso_sts_t                   i_sts,                  // Normal status sources
   input  wire sso_pkg::sso_alarm_t                 i_alarm,                // Alarm state and group
   input  wire sso_pkg::sso_warn_t                  i_warn,                 // Warning sources
   output logic                                     o_zero_speed_flag,      // Zero-speed output
   output logic                                     o_brake_interlock_out,  // Brake release allowed
   output logic                                     o_warning_out,          // Warning output
   output logic                                     o_battery_warning_out,  // Battery warning output
   output logic                                     o_assign_pin,           // Assignable output pin
   output logic [sso_pkg::CODE_W-1:0]               o_code_pins             // Code or status pins
);

   // ------------------------------------------------------------------
   // Zero-speed detection
   // ------------------------------------------------------------------
   logic zero_raw;

   // R2 threshold from config
   sso_zero_speed u_zero (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .i_speed     (i_speed),
      .i_speed_vld (i_speed_vld),
      .i_threshold (i_cfg.zero_speed_threshold_param),
      .o_zero      (zero_raw)
   );

   // ------------------------------------------------------------------
   // Start-up settle timer
   // ------------------------------------------------------------------
   localparam logic [sso_pkg::START_W-1:0] START_LAST = sso_pkg::START_W'(P_STARTUP_CYC - 1);

   logic [sso_pkg::START_W-1:0] start_cnt_ff;
   logic [sso_pkg::START_W-1:0] nxt_start_cnt;
   logic                        started_ff;
   logic                        nxt_started;

   // Warning sources are not trusted until the count expires
   always_comb begin
      nxt_start_cnt = start_cnt_ff;
      nxt_started   = started_ff;
      if (!started_ff) begin
         if (start_cnt_ff == START_LAST) nxt_started = 1'b1;
         else nxt_start_cnt = start_cnt_ff + 1'b1;
      end
   end

   // Timer registers
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         start_cnt_ff <= '0;
         started_ff   <= 1'b0;
      end else begin
         start_cnt_ff <= nxt_start_cnt;
         started_ff   <= nxt_started;
      end
   end

   // ------------------------------------------------------------------
   // Alarm code capture
   // ------------------------------------------------------------------
   logic                        alarm_hold_ff;
   logic                        nxt_alarm_hold;
   logic [sso_pkg::CODE_W-1:0]  code_ff;
   logic [sso_pkg::CODE_W-1:0]  nxt_code;

   // Group latched at onset so a changing source cannot flicker the pins
   always_comb begin
      nxt_alarm_hold = i_alarm.active;
      nxt_code       = code_ff;
      // R15 latch and hold
      if (i_alarm.active && !alarm_hold_ff) nxt_code = i_alarm.group;
   end

   // Alarm registers
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         alarm_hold_ff <= 1'b0;
         code_ff       <= '0;
      end else begin
         alarm_hold_ff <= nxt_alarm_hold;
         code_ff       <= nxt_code;
      end
   end

   // ------------------------------------------------------------------
   // Output selection
   // ------------------------------------------------------------------
   logic                        brake_en;
   logic                        code_en;
   logic                        warn_sel;
   logic                        batt_sel;
   logic                        brake_lvl;
   logic                        zero_lvl;
   logic                        warn_lvl;
   logic                        batt_lvl;
   logic                        nxt_zero;
   logic                        nxt_brake;
   logic                        nxt_warn;
   logic                        nxt_batt;
   logic                        nxt_assign;
   logic [sso_pkg::CODE_W-1:0]  nxt_pins;
   logic [sso_pkg::CODE_W-1:0]  normal_pins;

   // R6 brake enable
   assign brake_en = sso_pkg::sso_digit_on(i_cfg.function_select_param)
                     || (i_cfg.output_pin_assign_param == sso_pkg::SSO_PIN_BRAKE);
   // R13 code enable
   assign code_en  = sso_pkg::sso_digit_on(i_cfg.alarm_code_select_param);
   assign warn_sel = (i_cfg.output_pin_assign_param == sso_pkg::SSO_PIN_WARNING);
   assign batt_sel = (i_cfg.output_pin_assign_param == sso_pkg::SSO_PIN_BATTERY_WARN);
   // Ordinary status on the code pins when no code is shown
   assign normal_pins = {i_sts.ready, zero_lvl, i_sts.in_position_out};

   // Output levels before pin routing
   always_comb begin
      // R7 brake drop
      brake_lvl = brake_en && i_servo_on && !i_alarm.active;
      // R6 zero-speed masked
      zero_lvl  = zero_raw && !brake_en;
      // R9 quiet at start-up
      warn_lvl  = started_ff && i_warn.warning;
      // R10 battery sources
      // R11 quiet at start-up
      batt_lvl  = started_ff && (i_warn.battery_cable || i_warn.battery_low);
   end

   // Pin routing and dedicated outputs
   always_comb begin
      nxt_zero  = zero_lvl;
      nxt_brake = brake_lvl;
      // R8 only when assigned
      nxt_warn  = warn_sel && warn_lvl;
      nxt_batt  = batt_sel && batt_lvl;
      // R12 assignment replaces
      unique case (i_cfg.output_pin_assign_param)
         sso_pkg::SSO_PIN_SPEED_REACHED: nxt_assign = i_sts.speed_reached_out;
         sso_pkg::SSO_PIN_BRAKE:         nxt_assign = brake_lvl;
         sso_pkg::SSO_PIN_WARNING:       nxt_assign = warn_lvl;
         sso_pkg::SSO_PIN_BATTERY_WARN:  nxt_assign = batt_lvl;
      endcase
      // R14 code or normal status
      if (code_en && alarm_hold_ff) nxt_pins = code_ff;
      else nxt_pins = normal_pins;
   end

   // Output registers; every pin leaves a flip-flop
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_zero_speed_flag     <= 1'b0;
         o_brake_interlock_out <= 1'b0;
         o_warning_out         <= 1'b0;
         o_battery_warning_out <= 1'b0;
         o_assign_pin          <= 1'b0;
         o_code_pins           <= '0;
      end else begin
         o_zero_speed_flag     <= nxt_zero;
         o_brake_interlock_out <= nxt_brake;
         o_warning_out         <= nxt_warn;
         o_battery_warning_out <= nxt_batt;
         o_assign_pin          <= nxt_assign;
         o_code_pins           <= nxt_pins;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_alarm_rise;
      !alarm_hold_ff ##1 alarm_hold_ff;
   endsequence

   brake_drop_a: assert property (!i_servo_on || i_alarm.active |=> !o_brake_interlock_out)  // R7
      else $error("brake interlock stayed on without servo or with alarm");
   zero_mask_a: assert property (brake_en |=> !o_zero_speed_flag)  // R6
      else $error("zero-speed output active while brake interlock used");
   zero_pass_a: assert property (!brake_en && zero_raw |=> o_zero_speed_flag)  // R1
      else $error("zero-speed output missed the detector");
   warn_follow_a: assert property (started_ff && warn_sel && i_warn.warning |=> o_warning_out)  // R8
      else $error("warning output missed an assigned warning");
   warn_unassigned_a: assert property (!warn_sel |=> !o_warning_out)  // R8
      else $error("warning output active while not assigned");
   batt_follow_a: assert property (started_ff && batt_sel && (i_warn.battery_cable || i_warn.battery_low)
                                   |=> o_battery_warning_out)  // R10
      else $error("battery warning output missed a battery warning");
   startup_quiet_a: assert property (!started_ff |=> !o_warning_out && !o_battery_warning_out)  // R9
      else $error("warning outputs active before start-up settled");
   code_show_a: assert property (code_en && alarm_hold_ff |=> o_code_pins == $past(code_ff))  // R14
      else $error("alarm code not shown during alarm");
   code_normal_a: assert property (!alarm_hold_ff
                                   |=> o_code_pins == $past(normal_pins))  // R15
      else $error("pins did not return to normal status");
   code_hold_a: assert property (s_alarm_rise ##1 alarm_hold_ff |-> $stable(code_ff))  // R15
      else $error("alarm code changed while alarm held");
   code_off_a: assert property (!code_en |=> o_code_pins == $past(normal_pins))  // R13
      else $error("alarm code shown while code output disabled");
   assign_route_a: assert property (i_cfg.output_pin_assign_param == sso_pkg::SSO_PIN_SPEED_REACHED
                                    |=> o_assign_pin == $past(i_sts.speed_reached_out))  // R12
      else $error("assignable pin not routed to speed reached");

endmodule : sso_status_out

// ==== test/sso_host_model.sv ====
// Host controller model that reads the driver's discrete output lines
`timescale 1ns/1ps

module sso_host_model (
   input  wire logic       i_clk,    // 40 MHz clock
   input  wire logic       i_zero,   // Zero-speed line
   input  wire logic       i_brake,  // Brake interlock line
   input  wire logic       i_warn,   // Warning line
   input  wire logic       i_batt,   // Battery warning line
   input  wire logic       i_pin,    // Assignable line
   input  wire logic [2:0] i_code,   // Code or status lines
   output logic      [7:0] o_lines   // Lines as last read
);
   // ------------------------------------------------------------------
   // Line sampling
   // ------------------------------------------------------------------
   // Read mid-cycle, so the driver's lines have settled after its edge
   always @(negedge i_clk) begin
      o_lines <= {i_code, i_pin, i_batt, i_warn, i_brake, i_zero};
   end
endmodule : sso_host_model

// ==== test/sso_status_out_tb_top.sv ====
// Self-checking bench for the servo status output logic
`timescale 1ns/1ps

module sso_status_out_tb_top;
   localparam int P_ST = 16;  // Short start-up window for simulation
   logic                i_clk, i_rst_n, vld, servo, st, hold, e_z, e_b, e_w, e_bw, e_p;
   logic signed [15:0]  spd;
   sso_pkg::sso_cfg_t   cfg;
   sso_pkg::sso_sts_t   sts;
   sso_pkg::sso_alarm_t alm;
   sso_pkg::sso_warn_t  wrn;
   logic                z, b, w, bw, p;
   logic [2:0]          cp, code, e_cp;
   logic [7:0]          lines;
   int                  fail_count, num_checks, cnt;

   sso_status_out #(.P_STARTUP_CYC(P_ST)) u_sso_status_out (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_speed(spd),
      .i_speed_vld(vld), .i_servo_on(servo), .i_cfg(cfg), .i_sts(sts), .i_alarm(alm), .i_warn(wrn),
      .o_zero_speed_flag(z), .o_brake_interlock_out(b), .o_warning_out(w), .o_battery_warning_out(bw),
      .o_assign_pin(p), .o_code_pins(cp));
   sso_host_model u_sso_host_model (.i_clk(i_clk), .i_zero(z), .i_brake(b), .i_warn(w), .i_batt(bw),
      .i_pin(p), .i_code(cp), .o_lines(lines));

   // ------------------------------------------------------------------
   // Clock and watchdog
   // ------------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // Whole run is under a thousand cycles; five thousand means a hang
   initial begin
      #(5000 * 25);
      fail_count++;
      conclude();
   end

   // ------------------------------------------------------------------
   // Reference model
   // ------------------------------------------------------------------
   always @(posedge i_clk) begin : ref_model
      logic brk_en, brk, wv, bv;
      int   a, thr;
      a = (spd < 0) ? -int'(spd) : int'(spd);
      thr = int'(cfg.zero_speed_threshold_param);
      brk_en = cfg.function_select_param == 4'h1 || cfg.output_pin_assign_param == sso_pkg::SSO_PIN_BRAKE;
      brk = brk_en && servo && !alm.active;
      wv = cnt >= P_ST && wrn.warning;
      bv = cnt >= P_ST && (wrn.battery_cable || wrn.battery_low);
      if (!i_rst_n) begin
         {st, hold, code, e_z, e_b, e_w, e_bw, e_p, e_cp} <= '0;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
         if (vld && a <= thr) st <= 1'b1;
         else if (vld && a >= thr + int'(sso_pkg::ZERO_SPEED_HYST)) st <= 1'b0;
         e_z <= st && !brk_en;
         e_b <= brk;
         e_w <= wv && cfg.output_pin_assign_param == sso_pkg::SSO_PIN_WARNING;
         e_bw <= bv && cfg.output_pin_assign_param == sso_pkg::SSO_PIN_BATTERY_WARN;
         case (cfg.output_pin_assign_param)
            sso_pkg::SSO_PIN_SPEED_REACHED: e_p <= sts.speed_reached_out;
            sso_pkg::SSO_PIN_BRAKE:         e_p <= brk;
            sso_pkg::SSO_PIN_WARNING:       e_p <= wv;
            default:                        e_p <= bv;
         endcase
         hold <= alm.active;
         if (alm.active && !hold) code <= alm.group;
         e_cp <= (hold && cfg.alarm_code_select_param == 4'h1) ? code
                 : {sts.ready, st && !brk_en, sts.in_position_out};
      end
   end

   // ------------------------------------------------------------------
   // Comparison
   // ------------------------------------------------------------------
   task automatic chk_zero(input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t zero flag got %b exp %b", $time, got, exp);
      end
   endtask : chk_zero

   task automatic chk_out(input logic [6:0] exp, input logic [6:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t lines got %h exp %h", $time, got, exp);
      end
   endtask : chk_out

   // Model counts the start-up window edge for edge, so no cycle is left open
   always @(negedge i_clk) begin : cmp
      #1;
      if ($time > 60) begin
         chk_zero(e_z, lines[0]);
         chk_out({e_cp, e_p, e_bw, e_w, e_b}, lines[7:1]);
      end
   end

   // ------------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #2;
   endtask : cyc

   task automatic samp(input int s);
      spd = 16'(s);
      vld = 1'b1;
      cyc(1);
      vld = 1'b0;
      cyc(2);
   endtask : samp

   task automatic conclude();
      if (fail_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude

   initial begin
      int s;
      int sa[10];
      int sb[4];
      {vld, servo, spd, sts, alm} = '0;
      wrn = '1;
      cfg = '{16'h0032, 4'h0, 4'h1, sso_pkg::SSO_PIN_WARNING};
      i_rst_n = 1'b0;
      void'($urandom(32'h3d49));
      cyc(10);
      i_rst_n = 1'b1;
      // warnings held off while the outputs settle
      cyc(8);
      cfg.output_pin_assign_param = sso_pkg::SSO_PIN_BATTERY_WARN;
      cyc(12);
      // boundaries both ways at 50 r/min, then at 200 r/min
      sa = '{100, 50, 69, 70, -50, -69, -70, -32768, 0, 71};
      foreach (sa[i]) samp(sa[i]);
      cfg.zero_speed_threshold_param = 16'h00c8;
      sb = '{200, 219, 220, -199};
      foreach (sb[i]) samp(sb[i]);
      // groups 0 to 6 shown, group 7 with codes off, group change mid-alarm ignored
      servo = 1'b1;
      cfg.function_select_param = 4'h1;
      for (int g = 0; g < 8; g++) begin
         alm = '{1'b1, 3'(g)};
         cyc(3);
         alm.group = 3'(g + 3);
         cyc(3);
         alm.active = 1'b0;
         cyc(3);
         cfg.alarm_code_select_param = (g == 6) ? 4'h2 : 4'h1;
      end
      // Second reset in mid-run restarts the settle window
      i_rst_n = 1'b0;
      cyc(2);
      i_rst_n = 1'b1;
      // random traffic for each pin assignment
      for (int a = 0; a < 4; a++) begin
         cfg.output_pin_assign_param = sso_pkg::sso_pin_sel_t'(a);
         cfg.zero_speed_threshold_param = 16'($urandom_range(0, 200));
         repeat (150) begin
            s = int'(cfg.zero_speed_threshold_param) + int'($urandom_range(0, 40)) - 10;
            if ($urandom_range(0, 1) == 1) s = -s;
            spd = 16'(s);
            vld = 1'($urandom_range(0, 1));
            servo = $urandom_range(0, 3) != 0;
            sts = sso_pkg::sso_sts_t'(3'($urandom));
            wrn = sso_pkg::sso_warn_t'(3'($urandom));
            cfg.function_select_param = 4'($urandom_range(0, 2));
            cfg.alarm_code_select_param = 4'($urandom_range(0, 2));
            if ($urandom_range(0, 15) == 0) alm.active = ~alm.active;
            alm.group = 3'($urandom);
            cyc(1);
         end
      end
      vld = 1'b0;
      cyc(4);
      conclude();
   end
endmodule : sso_status_out_tb_top
